//--- shared/arsc_params.svh
/*
  Constants of the converter control block: register offsets, field positions,
  reset values and conversion lengths. Assumes inclusion by bare name.
*/
`ifndef ARSC_PARAMS_SVH
`define ARSC_PARAMS_SVH
`define ARSC_REG_MUX 3'h0
`define ARSC_REG_CTRL 3'h1
`define ARSC_REG_RES_LO 3'h2
`define ARSC_REG_RES_HI 3'h3
`define ARSC_REG_STAT 3'h4
`define ARSC_REG_MASK 3'h5
`define ARSC_MUX_REF_HI 7
`define ARSC_MUX_REF_LO 6
`define ARSC_MUX_LEFT 5
`define ARSC_MUX_CH_HI 3
`define ARSC_MUX_CH_LO 0
`define ARSC_CTRL_ON 7
`define ARSC_CTRL_START 6
`define ARSC_CTRL_FREE 5
`define ARSC_CTRL_PS_HI 2
`define ARSC_CTRL_PS_LO 0
`define ARSC_ST_DONE 0
`define ARSC_ST_SLEEP 1
`define ARSC_RESET_BYTE 8'h00
`define ARSC_REF_EXT 2'h0
`define ARSC_REF_RSVD 2'h2
`define ARSC_CODE_MAX 10'h3ff
`define ARSC_CYC_NORMAL 5'd13
`define ARSC_CYC_FIRST 5'd25
`define ARSC_SLEEP_IDLE 3'h0
`define ARSC_SLEEP_NOISE 3'h1
`endif

//--- shared/arsc_pkg.sv
/*
  Types of the converter control block: sequencer states and state records.
  Assumes arsc_params.svh supplies the numeric constants.
*/
package arsc_pkg;
  typedef enum logic [1:0] {
    ARSC_IDLE = 2'h0,
    ARSC_WAIT = 2'h1,
    ARSC_CONV = 2'h3
  } arsc_state_e;

  typedef struct packed {
    logic [6:0] cnt;
  } arsc_presc_s;

  typedef struct packed {
    logic [7:0] mux_temp;
    logic [1:0] ref_act;
    logic [3:0] chan_act;
    logic on;
    logic start;
    logic free;
    logic [2:0] presc;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [9:0] result;
    arsc_state_e st;
    logic [4:0] cnt;
    logic first;
    logic sleep_conv;
    logic sleeping;
    logic armed;
    logic [7:0] rdata;
    logic [10:0] code_s1;
    logic [10:0] code_s2;
  } arsc_state_s;
endpackage

//--- sim/adc_reference_sleep_control_tb.sv
/*
  Self-checking bench of the converter control block with a core model.
  Assumes arsc_params.svh on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "arsc_params.svh"
module adc_reference_sleep_control_tb;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic [2:0] mode = 3'h0;
  logic other_irq = 1'b0;
  logic [10:0] ana_code = 11'h000;
  logic [7:0] rdata;
  logic [7:0] d;
  logic sleep_enter, halted, wake, irq, power, int_ref, convert;
  logic [2:0] sleep_mode;
  logic [1:0] ref_sel;
  logic [3:0] channel;
  integer n_errors = 0;
  integer n_tests = 0;
  integer seed = 32'h953de7fb;
  integer i;
  integer exp_q[$];
  always #2 clk_sys_i = ~clk_sys_i;
  arsc_top dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sleep_enter_i(sleep_enter), .sleep_mode_i(sleep_mode),
    .cpu_halted_i(halted), .other_irq_i(other_irq), .wake_o(wake), .irq_o(irq),
    .ana_code_i(ana_code), .ana_power_o(power), .ana_int_ref_on_o(int_ref),
    .ana_ref_sel_o(ref_sel), .ana_channel_o(channel), .ana_convert_o(convert));
  arsc_core_model core_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .go_i(go), .mode_i(mode),
    .wake_i(wake), .other_i(other_irq), .sleep_enter_o(sleep_enter), .sleep_mode_o(sleep_mode),
    .halted_o(halted));
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_for(input bit use_wake);
    for (int k = 0; k < 400 && (use_wake ? wake : irq) !== 1'b1; k++) begin
      @(posedge clk_sys_i);
      #1;
    end
    chk(use_wake ? "wake" : "irq", 1, use_wake ? wake : irq);
  endtask
  // Start one conversion, check result in both alignments and the flags
  task automatic conv(input integer raw);
    integer e;
    integer p;
    exp_q.push_back(raw > 1023 ? 1023 : raw);
    ana_code <= raw[10:0];
    wr_reg(`ARSC_REG_CTRL, {6'b110000, raw[1:0]});
    wait_for(0);
    e = exp_q.pop_front();
    for (int l = 0; l < 2; l++) begin
      p = l ? e << 6 : e;
      wr_reg(`ARSC_REG_MUX, {2'b01, l[0], 5'h00});
      rd_reg(`ARSC_REG_RES_LO);
      chk("res_lo", p[7:0], d);
      rd_reg(`ARSC_REG_RES_HI);
      chk("res_hi", p[15:8], d);
    end
    rd_reg(`ARSC_REG_CTRL);
    chk("start", 0, d[6]);
    rd_reg(`ARSC_REG_STAT);
    chk("done", 1, d[0]);
    wr_reg(`ARSC_REG_STAT, 8'h03);
    rd_reg(`ARSC_REG_STAT);
    chk("cleared", 0, {irq, d});
  endtask
  task automatic sleep_cmd(input logic [2:0] m);
    @(posedge clk_sys_i);
    mode <= m;
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd_reg(`ARSC_REG_MUX);
    chk("mux_reset", 0, d);
    rd_reg(3'h7);
    chk("unmapped", 0, d);
    wr_reg(`ARSC_REG_MUX, 8'hff);
    rd_reg(`ARSC_REG_MUX);
    chk("mux_rw", 8'hef, d);
    wr_reg(`ARSC_REG_CTRL, 8'h80);
    wr_reg(`ARSC_REG_MASK, 8'h03);
    for (i = 0; i < 4; i++) begin
      wr_reg(`ARSC_REG_MUX, {i[1:0], 2'b00, 4'he - i[3:0]});
      rd_reg(`ARSC_REG_MUX);
      chk("mux_store", {i[1:0], 2'b00, 4'he - i[3:0]}, d);
      chk("ref_sel", (i == 2) ? 0 : i, ref_sel);
      chk("int_ref", i == 3, int_ref);
      chk("channel", 4'he - i[3:0], channel);
    end
    conv(0);
    conv(1023);
    conv($random(seed) & 1023);
    conv(1024 + ($random(seed) & 1023));
    // Free running: start stays set across completions
    wr_reg(`ARSC_REG_CTRL, 8'he0);
    wait_for(0);
    wr_reg(`ARSC_REG_STAT, 8'h01);
    wait_for(0);
    rd_reg(`ARSC_REG_CTRL);
    chk("free_run", 8'he0, d);
    wr_reg(`ARSC_REG_CTRL, 8'h00);
    wr_reg(`ARSC_REG_CTRL, 8'h80);
    wr_reg(`ARSC_REG_STAT, 8'h03);
    wr_reg(`ARSC_REG_MUX, 8'h40);
    wr_reg(`ARSC_REG_CTRL, 8'hc0);
    rd_reg(`ARSC_REG_STAT);
    wr_reg(`ARSC_REG_MUX, 8'hc0);
    rd_reg(`ARSC_REG_MUX);
    chk("ref_hold", {convert, 2'b01}, {1'b1, ref_sel});
    wait_for(0); // Result after reference switch discarded
    chk("ref_new", 3, ref_sel);
    wr_reg(`ARSC_REG_STAT, 8'h03);
    ana_code <= 11'h2a5;
    sleep_cmd(`ARSC_SLEEP_NOISE);
    wait_for(1);
    rd_reg(`ARSC_REG_STAT);
    chk("sleep_stat", {wake, 2'b11}, {1'b0, d[1:0]});
    rd_reg(`ARSC_REG_RES_LO);
    chk("sleep_res", 8'ha5, d);
    wr_reg(`ARSC_REG_STAT, 8'h03);
    sleep_cmd(`ARSC_SLEEP_IDLE);
    for (i = 0; i < 100 && convert !== 1'b1; i++) @(posedge clk_sys_i);
    other_irq <= 1'b1;
    @(posedge clk_sys_i);
    other_irq <= 1'b0;
    wait_for(0);
    chk("woken_early", 0, wake);
    wr_reg(`ARSC_REG_STAT, 8'h03);
    sleep_cmd(3'h2);
    repeat (60) @(posedge clk_sys_i);
    #1 chk("other_mode", 2'b10, {power, convert});
    other_irq <= 1'b1;
    @(posedge clk_sys_i);
    other_irq <= 1'b0;
    print_verdict();
  end
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
endmodule // adc_reference_sleep_control_tb
`default_nettype wire

//--- sim/arsc_core_model.sv
/*
  Core and sleep controller model: issues a sleep command, halts later, resumes on wake.
  Assumes the bench pulses go_i for one cycle with the mode beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module arsc_core_model (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic go_i,
  input wire logic [2:0] mode_i,
  input wire logic wake_i,
  input wire logic other_i,
  output logic sleep_enter_o,
  output logic [2:0] sleep_mode_o,
  output logic halted_o
);
  logic [1:0] dly;
  always_ff @(posedge clk_sys_i) begin
    sleep_enter_o <= go_i & ~reset_i; // One-cycle copy of go_i, held low during reset
    sleep_mode_o <= mode_i;
    if (reset_i || wake_i || other_i) begin
      halted_o <= 1'b0;
      dly <= 2'd0;
    end else if (go_i) begin
      dly <= 2'd3;
    end else if (dly != 2'd0) begin
      dly <= dly - 2'd1;
      halted_o <= (dly == 2'd1);
    end
  end
endmodule // arsc_core_model
`default_nettype wire

//--- verilog/arsc_prescaler.sv
/*
  Converter clock divider: one-cycle tick at 2,2,4,...,128 system clocks.
  Assumes the enable clears the count whenever the converter is off.
*/
`timescale 1ns/1ps
`default_nettype none
module arsc_prescaler (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic on_i,
  input wire logic [2:0] sel_i,
  output logic tick_o
);
  arsc_pkg::arsc_presc_s r;
  arsc_pkg::arsc_presc_s next_r;
  logic [6:0] last;

  always_comb begin
    last = (sel_i == 3'h0) ? 7'h01 : 7'((8'h01 << sel_i) - 8'h01);
    next_r = r;
    // At or past the limit, so a smaller divisor never waits for a wrap
    tick_o = on_i && (r.cnt >= last);
    if (!on_i || tick_o) begin
      next_r.cnt = 7'h00;
    end else begin
      next_r.cnt = 7'(r.cnt + 7'h01);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule // arsc_prescaler
`default_nettype wire

//--- verilog/arsc_result_fmt.sv
/*
  Result shaping: clamps the raw analog code to ten bits and presents the
  stored code right or left aligned as a byte pair. Purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "arsc_params.svh"
module arsc_result_fmt (
  input wire logic [10:0] raw_i,
  input wire logic [9:0] code_i,
  input wire logic left_i,
  output logic [9:0] clamped_o,
  output logic [7:0] low_o,
  output logic [7:0] high_o
);
  always_comb begin
    // Over-range saturates instead of wrapping
    clamped_o = raw_i[10] ? `ARSC_CODE_MAX : raw_i[9:0];
    if (left_i) begin
      high_o = code_i[9:2];
      low_o = {code_i[1:0], 6'h00};
    end else begin
      high_o = {6'h00, code_i[9:8]};
      low_o = code_i[7:0];
    end
  end
endmodule // arsc_result_fmt
`default_nettype wire

//--- verilog/arsc_top.sv
/*
  Converter control: input/reference select with safe-point buffering,
  conversion sequencer, result formatting, sleep-started conversions,
  status/mask interrupt. Assumes the analog core holds its code on ana_code_i
  (11 bits, bit 10 = over range) settled before the sequence ends.
*/
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "arsc_params.svh"
// Contract
// RULE_01 - Codes span 0x000 for ground up to 0x3FF for reference minus one step.
// RULE_02 - Inputs above the reference saturate at 0x3FF, never wrap.
// RULE_03 - Result registers hold the result once the done flag is high.
// RULE_04 - Reference select: 00 pin, 01 supply, 10 reserved, 11 internal.
// RULE_05 - Reference changes during a conversion apply only after it completes.
// RULE_06 - Select register: ref 7:6, left align 5, read-only 4, channel 3:0.
// RULE_07 - Software enables converter, idles it, single mode, enables done interrupt.
// RULE_08 - Sleep in idle or noise mode starts a conversion once core halts.
// RULE_09 - Done interrupt wakes the core when no other interrupt came first.
// RULE_10 - After an earlier wake, done request still raised on completion.
// RULE_11 - Once woken, the core stays active until the next sleep command.
// RULE_12 - Other sleep modes leave the converter enable untouched.
// RULE_13 - Software should discard the first result after a reference switch.
// RULE_14 - Left align presents the result in the pair at once.
// RULE_15 - Channel 0-7 inputs, 1110 bandgap, 1111 ground; changes wait for completion.
// RULE_16 - Completion writes result, sets flag, clears start in single mode.
// RULE_17 - Reserved reference code is stored as written, driven as pin.
module arsc_top (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic sleep_enter_i,
  input wire logic [2:0] sleep_mode_i,
  input wire logic cpu_halted_i,
  input wire logic other_irq_i,
  output logic wake_o,
  output logic irq_o,
  input wire logic [10:0] ana_code_i,
  output logic ana_power_o,
  output logic ana_int_ref_on_o,
  output logic [1:0] ana_ref_sel_o,
  output logic [3:0] ana_channel_o,
  output logic ana_convert_o
);
  arsc_pkg::arsc_state_s r;
  arsc_pkg::arsc_state_s next_r;
  logic tick;
  logic [9:0] clamped;
  logic [7:0] res_lo;
  logic [7:0] res_hi;
  logic [4:0] total;
  logic conv_done;
  logic wr_stat;
  logic sleep_ok;

  arsc_prescaler u_presc (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .on_i(r.on),
    .sel_i(r.presc),
    .tick_o(tick)
  );

  arsc_result_fmt u_fmt (
    .raw_i(r.code_s2),
    .code_i(r.result),
    .left_i(r.mux_temp[`ARSC_MUX_LEFT]),
    .clamped_o(clamped),
    .low_o(res_lo),
    .high_o(res_hi)
  );

  assign total = r.first ? `ARSC_CYC_FIRST : `ARSC_CYC_NORMAL;
  assign conv_done = (r.st == arsc_pkg::ARSC_CONV) && tick && (r.cnt == 5'(total - 5'd1));
  assign wr_stat = wr_i && (addr_i == `ARSC_REG_STAT);
  assign sleep_ok = (sleep_mode_i == `ARSC_SLEEP_IDLE) || (sleep_mode_i == `ARSC_SLEEP_NOISE);

  always_comb begin
    next_r = r;
    next_r.code_s1 = ana_code_i;
    next_r.code_s2 = r.code_s1;
    // Selection follows the buffer except while sampling is locked
    if (r.st != arsc_pkg::ARSC_CONV || conv_done) begin // see RULE_05 see RULE_15
      next_r.ref_act = r.mux_temp[`ARSC_MUX_REF_HI:`ARSC_MUX_REF_LO];
      next_r.chan_act = r.mux_temp[`ARSC_MUX_CH_HI:`ARSC_MUX_CH_LO];
    end
    if (wr_i) begin
      case (addr_i)
        `ARSC_REG_MUX: begin
          next_r.mux_temp = wdata_i & 8'hef; // see RULE_06 see RULE_17
        end
        `ARSC_REG_CTRL: begin
          next_r.on = wdata_i[`ARSC_CTRL_ON];
          next_r.free = wdata_i[`ARSC_CTRL_FREE];
          next_r.presc = wdata_i[`ARSC_CTRL_PS_HI:`ARSC_CTRL_PS_LO];
          if (wdata_i[`ARSC_CTRL_START] && wdata_i[`ARSC_CTRL_ON]) begin
            next_r.start = 1'b1;
          end
        end
        `ARSC_REG_MASK: begin
          next_r.mask = wdata_i[1:0];
        end
        default: begin
        end
      endcase
    end
    // Sleep command arms a sleep-time conversion when prepared
    if (sleep_enter_i) begin // see RULE_11
      next_r.sleeping = 1'b1;
      next_r.armed = sleep_ok && r.on && !r.start && !r.free && r.mask[`ARSC_ST_DONE]; // see RULE_12
    end else if (r.sleeping && (irq_o || other_irq_i)) begin // see RULE_09
      next_r.sleeping = 1'b0;
    end
    if (r.armed && cpu_halted_i) begin // see RULE_08
      next_r.armed = 1'b0;
      next_r.start = 1'b1;
      next_r.sleep_conv = 1'b1;
    end
    if (wr_stat) begin
      next_r.stat = r.stat & ~wdata_i[1:0];
    end
    case (r.st)
      arsc_pkg::ARSC_IDLE: begin
        if (r.start) begin
          next_r.st = arsc_pkg::ARSC_WAIT;
        end
      end
      arsc_pkg::ARSC_WAIT: begin
        if (tick) begin
          next_r.st = arsc_pkg::ARSC_CONV;
          next_r.cnt = 5'd0;
        end
      end
      arsc_pkg::ARSC_CONV: begin
        if (conv_done) begin
          next_r.result = clamped; // see RULE_01 see RULE_02
          next_r.stat[`ARSC_ST_DONE] = 1'b1; // see RULE_03 see RULE_10 see RULE_16
          next_r.stat[`ARSC_ST_SLEEP] = next_r.stat[`ARSC_ST_SLEEP] | r.sleep_conv;
          next_r.sleep_conv = 1'b0;
          next_r.first = 1'b0;
          next_r.cnt = 5'd0;
          if (!r.free) begin
            next_r.start = 1'b0; // see RULE_16
            next_r.st = arsc_pkg::ARSC_IDLE;
          end
        end else if (tick) begin
          next_r.cnt = 5'(r.cnt + 5'd1);
        end
      end
      default: begin
        next_r.st = arsc_pkg::ARSC_IDLE;
      end
    endcase
    // Switching off aborts and makes the next conversion extended
    if (!next_r.on) begin
      next_r.st = arsc_pkg::ARSC_IDLE;
      next_r.start = 1'b0;
      next_r.first = 1'b1;
      next_r.sleep_conv = 1'b0;
      next_r.armed = 1'b0;
    end
    next_r.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `ARSC_REG_MUX: next_r.rdata = r.mux_temp;
        `ARSC_REG_CTRL: next_r.rdata = {r.on, r.start, r.free, 2'h0, r.presc};
        `ARSC_REG_RES_LO: next_r.rdata = res_lo; // see RULE_14
        `ARSC_REG_RES_HI: next_r.rdata = res_hi; // see RULE_14
        `ARSC_REG_STAT: next_r.rdata = {6'h00, r.stat};
        `ARSC_REG_MASK: next_r.rdata = {6'h00, r.mask};
        default: next_r.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      r <= '0;
      r.mux_temp <= `ARSC_RESET_BYTE;
      r.first <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign rdata_o = r.rdata;
  assign irq_o = |(r.stat & r.mask);
  assign wake_o = r.sleeping && irq_o;
  assign ana_power_o = r.on;
  assign ana_convert_o = (r.st == arsc_pkg::ARSC_CONV);
  assign ana_channel_o = r.chan_act;
  // Reserved code drives the pin selection
  assign ana_ref_sel_o = (r.ref_act == `ARSC_REF_RSVD) ? `ARSC_REF_EXT : r.ref_act; // see RULE_04 see RULE_17
  assign ana_int_ref_on_o = (r.ref_act == 2'h3); // see RULE_04

  sequence s_finish;
    conv_done ##1 (r.stat[`ARSC_ST_DONE] && r.result == $past(clamped));
  endsequence

  property p_scale;
    @(posedge clk_sys_i) disable iff (reset_i)
      conv_done && !r.code_s2[10] |=> r.result == $past(r.code_s2[9:0]);
  endproperty
  a_scale: assert property (p_scale) else $error("result differs from in-range code"); // see RULE_01

  property p_clamp;
    @(posedge clk_sys_i) disable iff (reset_i)
      conv_done && r.code_s2[10] |=> r.result == `ARSC_CODE_MAX;
  endproperty
  a_clamp: assert property (p_clamp) else $error("over-range code not saturated"); // see RULE_02

  property p_finish;
    @(posedge clk_sys_i) disable iff (reset_i)
      conv_done |-> s_finish;
  endproperty
  a_finish: assert property (p_finish) else $error("completion did not post result and flag"); // see RULE_03

  property p_single_clear;
    @(posedge clk_sys_i) disable iff (reset_i)
      conv_done && !r.free |=> !r.start && r.st == arsc_pkg::ARSC_IDLE;
  endproperty
  a_single_clear: assert property (p_single_clear) else $error("start not cleared at completion"); // see RULE_16

  property p_ref_lock;
    @(posedge clk_sys_i) disable iff (reset_i)
      r.st == arsc_pkg::ARSC_CONV && !conv_done |=> r.ref_act == $past(r.ref_act) && r.chan_act == $past(r.chan_act);
  endproperty
  a_ref_lock: assert property (p_ref_lock) else $error("selection changed mid conversion"); // see RULE_05

  property p_chan_follow;
    @(posedge clk_sys_i) disable iff (reset_i)
      r.st == arsc_pkg::ARSC_IDLE ##1 r.st == arsc_pkg::ARSC_IDLE |-> r.chan_act == $past(r.mux_temp[3:0]);
  endproperty
  a_chan_follow: assert property (p_chan_follow) else $error("channel not following buffer when idle"); // see RULE_15

  property p_bit4;
    @(posedge clk_sys_i) disable iff (reset_i)
      rd_i && addr_i == `ARSC_REG_MUX |=> rdata_o[4] == 1'b0;
  endproperty
  a_bit4: assert property (p_bit4) else $error("read-only select bit not zero"); // see RULE_06

  property p_sleep_start;
    @(posedge clk_sys_i) disable iff (reset_i)
      r.armed && cpu_halted_i && r.on |=> r.start ##[1:2] r.st == arsc_pkg::ARSC_WAIT;
  endproperty
  a_sleep_start: assert property (p_sleep_start) else $error("sleep conversion not started"); // see RULE_08

  property p_wake;
    @(posedge clk_sys_i) disable iff (reset_i)
      r.sleeping && irq_o && !sleep_enter_i |-> wake_o ##1 !r.sleeping;
  endproperty
  a_wake: assert property (p_wake) else $error("done interrupt did not wake core"); // see RULE_09

  property p_stay_active;
    @(posedge clk_sys_i) disable iff (reset_i)
      !r.sleeping && !sleep_enter_i |=> !r.sleeping;
  endproperty
  a_stay_active: assert property (p_stay_active) else $error("core slept without command"); // see RULE_11

  property p_other_mode;
    @(posedge clk_sys_i) disable iff (reset_i)
      sleep_enter_i && !sleep_ok && !wr_i |=> !r.armed && r.on == $past(r.on);
  endproperty
  a_other_mode: assert property (p_other_mode) else $error("other sleep mode touched converter"); // see RULE_12

  property p_left;
    @(posedge clk_sys_i) disable iff (reset_i)
      rd_i && addr_i == `ARSC_REG_RES_HI && r.mux_temp[5] |=> rdata_o == $past(r.result[9:2]);
  endproperty
  a_left: assert property (p_left) else $error("left aligned high byte wrong"); // see RULE_14

  property p_set_wins;
    @(posedge clk_sys_i) disable iff (reset_i)
      conv_done && wr_stat |=> r.stat[`ARSC_ST_DONE];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag clear overrode completion"); // see RULE_16

  property p_sleep_flag;
    @(posedge clk_sys_i) disable iff (reset_i)
      conv_done && r.sleep_conv |=> r.stat[`ARSC_ST_SLEEP] && r.stat[`ARSC_ST_DONE];
  endproperty
  a_sleep_flag: assert property (p_sleep_flag) else $error("sleep conversion flag not set"); // see RULE_08

  property p_late_irq;
    @(posedge clk_sys_i) disable iff (reset_i)
      conv_done && r.mask[`ARSC_ST_DONE] && !(wr_i && addr_i == `ARSC_REG_MASK) |=> irq_o;
  endproperty
  a_late_irq: assert property (p_late_irq) else $error("completion raised no request"); // see RULE_10

  property p_rsvd_ref;
    @(posedge clk_sys_i) disable iff (reset_i)
      r.ref_act == `ARSC_REF_RSVD |-> ana_ref_sel_o == `ARSC_REF_EXT && !ana_int_ref_on_o;
  endproperty
  a_rsvd_ref: assert property (p_rsvd_ref) else $error("reserved reference not driven as pin"); // see RULE_17

  property p_right;
    @(posedge clk_sys_i) disable iff (reset_i)
      rd_i && addr_i == `ARSC_REG_RES_HI && !r.mux_temp[`ARSC_MUX_LEFT]
      |=> rdata_o == {6'h00, $past(r.result[9:8])};
  endproperty
  a_right: assert property (p_right) else $error("right aligned high byte wrong"); // see RULE_14
endmodule // arsc_top
`default_nettype wire
